// ---- csp_can_sync_position_loop.sv ----
// can synchronised position loop: staging, sync copies, resets, reply
// assumes parameter accesses and sync commands arrive already decoded
// from can frames, synchronous to clk
// Function
// - mode 15 runs proportional position loop with feed-forward from can
// - feedback from resolver when select is 0, encoder when 1
// - active feed-forward speed, up to 9000 rpm, added to loop output
// - sync copies staged feed-forward speed into active feed-forward
// - sync copies staged position reference into active reference
// - sync captures measured motor position into feedback transmit register
// - type-0 feedback enable transmits captured position on type 0 sync
// - type-1 feedback enable transmits captured position on type 1 sync
// - reply status is 16 bits when format flag 0, low 8 when 1
// - selector 0 and low-speed flag select 500 kbit/s link rate
// - sync command sets sync flag; device clears it after copies
// - zero reset command forces motor position and reference to zero
// - shaft reset loads position and reference with shaft angle, clears aux
// - follow reset copies position into reference and clears aux
module csp_can_sync_position_loop #(
  parameter int unsigned LOOP_CYCLES = csp_pkg::LOOP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic par_wr,
  input wire logic par_rd,
  input wire logic [7:0] par_num,
  input wire logic [15:0] par_wdata,
  output logic [15:0] par_rdata,
  output logic par_rvalid,
  input wire logic sync_cmd,
  input wire logic sync_type,
  input wire logic [3:0] operating_mode,
  input wire logic feedback_source_select,
  input wire logic [15:0] resolver_delta,
  input wire logic [15:0] encoder_delta,
  input wire logic [15:0] shaft_angle,
  input wire logic [7:0] link_rate_selector,
  input wire logic [15:0] loop_gain,
  output logic [15:0] speed_request,
  output logic loop_active,
  output logic fb_tx_valid,
  output logic fb_tx_type,
  output logic [31:0] fb_tx_data,
  output logic [15:0] reply_status,
  output logic can_low_rate,
  output logic can_bit_tick,
  output logic [31:0] active_position_reference,
  output logic [31:0] measured_motor_position,
  output logic [31:0] auxiliary_position_count
);

  // ==========================================================
  // parameter registers
  logic [15:0] can_status_primary;
  logic [15:0] can_status_word;
  logic [15:0] feedforward_speed_active;
  logic [15:0] feedforward_speed_staged;
  logic [31:0] position_reference_staged;
  logic [31:0] position_feedback_tx;
  logic [15:0] mode_command_flags;
  logic sync_kind;

  function automatic logic [15:0] clamp_ff(input logic [15:0] v);
    if ($signed(v) > $signed(csp_pkg::FF_MAX)) begin
      clamp_ff = csp_pkg::FF_MAX;
    end else if ($signed(v) < $signed(csp_pkg::FF_MIN)) begin
      clamp_ff = csp_pkg::FF_MIN;
    end else begin
      clamp_ff = v;
    end
  endfunction

  // ==========================================================
  // decode
  wire logic wr_prim = par_wr && par_num == csp_pkg::PAR_STATUS_PRIMARY;
  wire logic wr_stat = par_wr && par_num == csp_pkg::PAR_STATUS_WORD;
  wire logic wr_ffa = par_wr && par_num == csp_pkg::PAR_FF_ACTIVE;
  wire logic wr_ffs = par_wr && par_num == csp_pkg::PAR_FF_STAGED;
  wire logic wr_rsl = par_wr && par_num == csp_pkg::PAR_REF_STAGED_LO;
  wire logic wr_rsh = par_wr && par_num == csp_pkg::PAR_REF_STAGED_HI;
  wire logic wr_ftl = par_wr && par_num == csp_pkg::PAR_FB_TX_LO;
  wire logic wr_fth = par_wr && par_num == csp_pkg::PAR_FB_TX_HI;
  wire logic wr_flg = par_wr && par_num == csp_pkg::PAR_MODE_FLAGS;

  wire logic sync_flag = mode_command_flags[csp_pkg::BIT_SYNC];
  wire logic zero_reset_cmd = mode_command_flags[csp_pkg::BIT_ZERO_RST];
  wire logic shaft_reset_cmd = mode_command_flags[csp_pkg::BIT_SHAFT_RST];
  wire logic follow_reset_cmd = mode_command_flags[csp_pkg::BIT_FOLLOW_RST];
  wire logic type0_feedback_enable = mode_command_flags[csp_pkg::BIT_FB0_EN];
  wire logic type1_feedback_enable = mode_command_flags[csp_pkg::BIT_FB1_EN];
  wire logic reply_format_flag = mode_command_flags[csp_pkg::BIT_REPLY_FMT];
  wire logic low_speed_flag = mode_command_flags[csp_pkg::BIT_LOW_SPEED];

  // ==========================================================
  // command flags
  // a sync arriving while the previous one is being cleared survives
  wire logic sync_set = sync_cmd ||
    (wr_flg && par_wdata[csp_pkg::BIT_SYNC]);
  // resets wait while a sync is pending so its copies see stable values
  wire logic do_zero = zero_reset_cmd && !sync_flag;
  wire logic do_shaft = shaft_reset_cmd && !sync_flag && !zero_reset_cmd;
  wire logic do_follow = follow_reset_cmd && !sync_flag &&
    !zero_reset_cmd && !shaft_reset_cmd;
  wire logic [15:0] hw_clear = {
    3'b000, do_follow, do_shaft, do_zero, 1'b0, sync_flag, 8'h00};
  wire logic [15:0] cmd_set = (wr_flg ? par_wdata : csp_pkg::RST_16) &
    csp_pkg::FLAG_CMD_MASK;
  wire logic [15:0] cfg_part = wr_flg ?
    (par_wdata & ~csp_pkg::FLAG_CMD_MASK) :
    (mode_command_flags & ~csp_pkg::FLAG_CMD_MASK);
  wire logic [15:0] cmd_part = (mode_command_flags &
    csp_pkg::FLAG_CMD_MASK & ~hw_clear) | cmd_set;
  wire logic [15:0] next_flags = cfg_part | cmd_part |
    (sync_cmd ? (16'h0001 << csp_pkg::BIT_SYNC) : csp_pkg::RST_16);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_command_flags <= csp_pkg::RST_16;
      sync_kind <= 1'b0;
    end else begin
      mode_command_flags <= next_flags;
      if (sync_cmd) begin
        sync_kind <= sync_type;
      end
    end
  end

  // ==========================================================
  // feedback and position counters
  wire logic [15:0] sel_delta = feedback_source_select ?
    encoder_delta : resolver_delta;
  wire logic [31:0] delta_ext = {{16{sel_delta[15]}}, sel_delta};
  wire logic [31:0] shaft_ext = {csp_pkg::RST_16, shaft_angle};

  wire logic [31:0] next_meas = do_zero ? csp_pkg::RST_32 :
    do_shaft ? shaft_ext :
    measured_motor_position + delta_ext;
  wire logic [31:0] next_aux = (do_shaft || do_follow) ?
    csp_pkg::RST_32 : auxiliary_position_count + delta_ext;
  wire logic [31:0] next_ref = sync_flag ? position_reference_staged :
    do_zero ? csp_pkg::RST_32 :
    do_shaft ? shaft_ext :
    do_follow ? measured_motor_position :
    active_position_reference;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      measured_motor_position <= csp_pkg::RST_32;
      auxiliary_position_count <= csp_pkg::RST_32;
      active_position_reference <= csp_pkg::RST_32;
    end else begin
      measured_motor_position <= next_meas;
      auxiliary_position_count <= next_aux;
      active_position_reference <= next_ref;
    end
  end

  // ==========================================================
  // staged and active references
  // the sync copy beats a same-cycle write so the loop sees one set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      feedforward_speed_active <= csp_pkg::RST_16;
      feedforward_speed_staged <= csp_pkg::RST_16;
      position_reference_staged <= csp_pkg::RST_32;
      position_feedback_tx <= csp_pkg::RST_32;
    end else begin
      if (sync_flag) begin
        feedforward_speed_active <= clamp_ff(feedforward_speed_staged);
      end else if (wr_ffa) begin
        feedforward_speed_active <= clamp_ff(par_wdata);
      end
      if (wr_ffs) begin
        feedforward_speed_staged <= par_wdata;
      end
      if (wr_rsl) begin
        position_reference_staged[15:0] <= par_wdata;
      end
      if (wr_rsh) begin
        position_reference_staged[31:16] <= par_wdata;
      end
      if (sync_flag) begin
        position_feedback_tx <= measured_motor_position;
      end else begin
        if (wr_ftl) begin
          position_feedback_tx[15:0] <= par_wdata;
        end
        if (wr_fth) begin
          position_feedback_tx[31:16] <= par_wdata;
        end
      end
    end
  end

  // ==========================================================
  // feedback transmit request
  wire logic tx_due = sync_flag && (sync_kind ?
    type1_feedback_enable : type0_feedback_enable);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fb_tx_valid <= 1'b0;
      fb_tx_type <= 1'b0;
      fb_tx_data <= csp_pkg::RST_32;
    end else begin
      fb_tx_valid <= tx_due;
      if (tx_due) begin
        fb_tx_type <= sync_kind;
        fb_tx_data <= measured_motor_position;
      end
    end
  end

  // ==========================================================
  // status words and reply
  wire logic [15:0] next_reply = reply_format_flag ?
    {csp_pkg::BYTE_ZERO, can_status_word[7:0]} : can_status_word;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      can_status_primary <= csp_pkg::RST_16;
      can_status_word <= csp_pkg::RST_16;
      reply_status <= csp_pkg::RST_16;
    end else begin
      if (wr_prim) begin
        can_status_primary <= par_wdata;
      end
      if (wr_stat) begin
        can_status_word <= par_wdata;
      end
      reply_status <= next_reply;
    end
  end

  // ==========================================================
  // parameter read port
  wire logic [15:0] rd_value =
    par_num == csp_pkg::PAR_STATUS_PRIMARY ? can_status_primary :
    par_num == csp_pkg::PAR_STATUS_WORD ? can_status_word :
    par_num == csp_pkg::PAR_FF_ACTIVE ? feedforward_speed_active :
    par_num == csp_pkg::PAR_FF_STAGED ? feedforward_speed_staged :
    par_num == csp_pkg::PAR_REF_STAGED_LO ? position_reference_staged[15:0] :
    par_num == csp_pkg::PAR_REF_STAGED_HI ? position_reference_staged[31:16] :
    par_num == csp_pkg::PAR_FB_TX_LO ? position_feedback_tx[15:0] :
    par_num == csp_pkg::PAR_FB_TX_HI ? position_feedback_tx[31:16] :
    par_num == csp_pkg::PAR_MODE_FLAGS ? mode_command_flags :
    csp_pkg::RST_16;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      par_rdata <= csp_pkg::RST_16;
      par_rvalid <= 1'b0;
    end else begin
      par_rvalid <= par_rd;
      if (par_rd) begin
        par_rdata <= rd_value;
      end
    end
  end

  // ==========================================================
  // control-rate tick and can bit-rate enable
  logic [15:0] loop_count;
  logic [15:0] bit_count;
  wire logic loop_tick = loop_count == 16'(LOOP_CYCLES - 1);
  wire logic low_rate = link_rate_selector ==
    csp_pkg::LINK_RATE_SEL_DEFAULT && low_speed_flag;
  wire logic [15:0] bit_last = low_rate ?
    16'(csp_pkg::CAN_SLOW_CYCLES - 1) : 16'(csp_pkg::CAN_FAST_CYCLES - 1);
  // a rate change takes effect within the current count, >= guards shrink
  wire logic bit_wrap = bit_count >= bit_last;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_count <= csp_pkg::RST_16;
      bit_count <= csp_pkg::RST_16;
      can_bit_tick <= 1'b0;
      can_low_rate <= 1'b0;
      loop_active <= 1'b0;
    end else begin
      loop_count <= loop_tick ? csp_pkg::RST_16 : loop_count + 16'h0001;
      bit_count <= bit_wrap ? csp_pkg::RST_16 : bit_count + 16'h0001;
      can_bit_tick <= bit_wrap;
      can_low_rate <= low_rate;
      loop_active <= operating_mode == csp_pkg::OPMODE_CAN_POS;
    end
  end

  // ==========================================================
  // position loop
  csp_pos_loop u_loop (
    .clk(clk),
    .rst(rst),
    .tick(loop_tick),
    .enable(loop_active),
    .reference(active_position_reference),
    .position(measured_motor_position),
    .gain(loop_gain),
    .feedforward(feedforward_speed_active),
    .speed_request(speed_request)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_sync_pending;
    sync_flag && !sync_set;
  endsequence

  sequence s_sync_t0;
    sync_flag && !sync_kind && type0_feedback_enable;
  endsequence

  chk_sync_self_clear: assert property (
    s_sync_pending |=> !sync_flag)
    else $error("sync flag not cleared");
  chk_ff_copy_sync: assert property (
    sync_flag |=> feedforward_speed_active ==
      clamp_ff($past(feedforward_speed_staged)))
    else $error("feed-forward not copied on sync");
  chk_ref_copy_sync: assert property (
    sync_flag |=> active_position_reference ==
      $past(position_reference_staged))
    else $error("reference not copied on sync");
  chk_fb_capture_sync: assert property (
    sync_flag |=> position_feedback_tx == $past(measured_motor_position))
    else $error("position not captured on sync");
  chk_tx_type_zero: assert property (
    s_sync_t0 |=> fb_tx_valid && !fb_tx_type &&
      fb_tx_data == position_feedback_tx)
    else $error("type 0 feedback not sent");
  chk_tx_type_one: assert property (
    sync_flag && sync_kind && !type1_feedback_enable |=> !fb_tx_valid)
    else $error("type 1 feedback sent while disabled");
  chk_reply_short_fmt: assert property (
    reply_format_flag ##1 reply_format_flag |->
      reply_status[15:8] == csp_pkg::BYTE_ZERO)
    else $error("short reply carries high byte");
  chk_low_rate_sel: assert property (
    low_speed_flag && link_rate_selector == csp_pkg::LINK_RATE_SEL_DEFAULT
    |=> can_low_rate)
    else $error("low link rate not selected");
  chk_zero_reset_pos: assert property (
    do_zero |=> measured_motor_position == csp_pkg::RST_32 &&
      active_position_reference == csp_pkg::RST_32 && !zero_reset_cmd)
    else $error("zero reset not applied");
  chk_follow_reset: assert property (
    do_follow |=> active_position_reference ==
      $past(measured_motor_position) &&
      auxiliary_position_count == csp_pkg::RST_32)
    else $error("follow reset not applied");

endmodule // csp_can_sync_position_loop

// ---- csp_pkg.sv ----
// constants shared by the can synchronised position loop
// assumes a single 200 MHz control clock and parameter-number access
package csp_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned LOOP_PERIOD_US = 100;
  localparam int unsigned LOOP_CYCLES = LOOP_PERIOD_US * CLK_MHZ;
  localparam int unsigned CAN_FAST_KBPS = 1000;
  localparam int unsigned CAN_SLOW_KBPS = 500;
  localparam int unsigned CAN_FAST_CYCLES = CLK_MHZ * 1000 / CAN_FAST_KBPS;
  localparam int unsigned CAN_SLOW_CYCLES = CLK_MHZ * 1000 / CAN_SLOW_KBPS;

  // ==========================================================
  // operating mode and link selector
  localparam logic [3:0] OPMODE_CAN_POS = 4'hf;
  localparam logic [7:0] LINK_RATE_SEL_DEFAULT = 8'h00;

  // ==========================================================
  // parameter numbers
  localparam logic [7:0] PAR_STATUS_PRIMARY = 8'h66;
  localparam logic [7:0] PAR_STATUS_WORD = 8'h67;
  localparam logic [7:0] PAR_FF_ACTIVE = 8'h68;
  localparam logic [7:0] PAR_FF_STAGED = 8'h69;
  localparam logic [7:0] PAR_REF_STAGED_LO = 8'h72;
  localparam logic [7:0] PAR_REF_STAGED_HI = 8'h73;
  localparam logic [7:0] PAR_FB_TX_LO = 8'h74;
  localparam logic [7:0] PAR_FB_TX_HI = 8'h75;
  localparam logic [7:0] PAR_MODE_FLAGS = 8'h96;

  // ==========================================================
  // mode_command_flags bit positions
  localparam int unsigned BIT_FB0_EN = 2;
  localparam int unsigned BIT_REPLY_FMT = 3;
  localparam int unsigned BIT_LOW_SPEED = 4;
  localparam int unsigned BIT_FB1_EN = 6;
  localparam int unsigned BIT_SYNC = 8;
  localparam int unsigned BIT_ZERO_RST = 10;
  localparam int unsigned BIT_SHAFT_RST = 11;
  localparam int unsigned BIT_FOLLOW_RST = 12;
  // command bits: write one to set, hardware clears
  localparam logic [15:0] FLAG_CMD_MASK = 16'h1d00;

  // ==========================================================
  // reset values and limits
  localparam logic [15:0] RST_16 = 16'h0000;
  localparam logic [31:0] RST_32 = 32'h0000_0000;
  localparam logic [15:0] FF_MAX = 16'h2328;
  localparam logic [15:0] FF_MIN = 16'hdcd8;
  localparam logic [15:0] SPEED_MAX = 16'h2328;
  localparam logic [15:0] SPEED_MIN = 16'hdcd8;
  localparam int unsigned KP_SHIFT = 8;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

endpackage

// ---- csp_pos_loop.sv ----
// proportional position loop with speed feed-forward and saturation
// assumes tick is a one-cycle enable at the control rate
module csp_pos_loop (
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic [31:0] reference,
  input wire logic [31:0] position,
  input wire logic [15:0] gain,
  input wire logic [15:0] feedforward,
  output logic [15:0] speed_request
);

  // ==========================================================
  // arithmetic
  // error kept at full width so large following errors saturate
  // instead of wrapping into the wrong direction
  wire logic signed [31:0] pos_error;
  wire logic signed [48:0] prop_full;
  wire logic signed [48:0] prop_scaled;
  wire logic signed [48:0] sum_full;
  wire logic over_max;
  wire logic under_min;
  wire logic [15:0] sat_value;

  assign pos_error = $signed(reference - position);
  assign prop_full = 49'(pos_error * $signed({1'b0, gain}));
  assign prop_scaled = prop_full >>> csp_pkg::KP_SHIFT;
  assign sum_full = prop_scaled + 49'($signed(feedforward));
  assign over_max = sum_full > 49'($signed(csp_pkg::SPEED_MAX));
  assign under_min = sum_full < 49'($signed(csp_pkg::SPEED_MIN));
  assign sat_value = over_max ? csp_pkg::SPEED_MAX :
                     under_min ? csp_pkg::SPEED_MIN : sum_full[15:0];

  // ==========================================================
  // output register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_request <= csp_pkg::RST_16;
    end else if (!enable) begin
      speed_request <= csp_pkg::RST_16;
    end else if (tick) begin
      speed_request <= sat_value;
    end
  end

endmodule // csp_pos_loop

// ---- csp_profile_gen.sv ----
// profile generator model: parameter accesses and sync commands
// assumes its tasks are called from the bench on a falling clock edge
module csp_profile_gen (
  input wire logic clk,
  output logic par_wr,
  output logic par_rd,
  output logic [7:0] par_num,
  output logic [15:0] par_wdata,
  input wire logic [15:0] par_rdata,
  input wire logic par_rvalid,
  output logic sync_cmd,
  output logic sync_type
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // idle bus
  initial begin
    par_wr = 1'b0;
    par_rd = 1'b0;
    par_num = 8'h00;
    par_wdata = 16'h0000;
    sync_cmd = 1'b0;
    sync_type = 1'b0;
  end
  // ====
  // requests; a released bus shows inverted values, never the last ones
  task automatic wr(input logic [7:0] num, input logic [15:0] data);
    @(negedge clk);
    par_num = num;
    par_wdata = data;
    par_wr = 1'b1;
    @(negedge clk);
    par_wr = 1'b0;
    par_num = ~num;
    par_wdata = ~data;
  endtask
  task automatic rd(input logic [7:0] num, output logic [15:0] data,
                    output logic ok);
    @(negedge clk);
    par_num = num;
    par_rd = 1'b1;
    @(negedge clk);
    par_rd = 1'b0;
    par_num = ~num;
    ok = par_rvalid;
    data = par_rdata;
  endtask
  task automatic sync(input logic t);
    @(negedge clk);
    sync_type = t;
    sync_cmd = 1'b1;
    @(negedge clk);
    sync_cmd = 1'b0;
    sync_type = ~t;
  endtask
endmodule // csp_profile_gen

// ---- can_sync_position_loop_tb.sv ----
// self-checking bench for the can synchronised position loop
// assumes csp_pkg and the design files are compiled first
`define CHK(what, exp, got) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); \
  end \
end
module can_sync_position_loop_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] num;
    logic [15:0] wdata;
    logic [15:0] exp;
  } csp_row_t;
  logic clk = 1'b0;
  logic rst, par_wr, par_rd, par_rvalid, sync_cmd, sync_type, fbsel;
  logic [7:0] par_num, rate_sel;
  logic [15:0] par_wdata, par_rdata, res_d, enc_d, shaft, gain, speed;
  logic [15:0] reply;
  logic [3:0] mode;
  logic loop_on, tx_v, tx_t, low_rate, bit_tick;
  logic [31:0] tx_d, act_ref, meas, aux;
  logic [31:0] ref_staged = 32'h0000_1111;
  int failures = 0;
  int checks = 0;
  csp_row_t rows[8] = '{
    '{8'h66, 16'h1234, 16'h1234}, '{8'h67, 16'habcd, 16'habcd},
    '{8'h68, 16'h3000, 16'h2328}, '{8'h69, 16'h0064, 16'h0064},
    '{8'h72, 16'h1111, 16'h1111}, '{8'h74, 16'h0007, 16'h0007},
    '{8'h96, 16'h005c, 16'h005c}, '{8'h10, 16'hffff, 16'h0000}};
  always #2.5 clk = ~clk;
  // ====
  // design and far side
  csp_can_sync_position_loop #(.LOOP_CYCLES(8)) DUT (
    .clk(clk), .rst(rst), .par_wr(par_wr), .par_rd(par_rd),
    .par_num(par_num), .par_wdata(par_wdata), .par_rdata(par_rdata),
    .par_rvalid(par_rvalid), .sync_cmd(sync_cmd), .sync_type(sync_type),
    .operating_mode(mode), .feedback_source_select(fbsel),
    .resolver_delta(res_d), .encoder_delta(enc_d), .shaft_angle(shaft),
    .link_rate_selector(rate_sel), .loop_gain(gain),
    .speed_request(speed), .loop_active(loop_on), .fb_tx_valid(tx_v),
    .fb_tx_type(tx_t), .fb_tx_data(tx_d), .reply_status(reply),
    .can_low_rate(low_rate), .can_bit_tick(bit_tick),
    .active_position_reference(act_ref),
    .measured_motor_position(meas), .auxiliary_position_count(aux));
  csp_profile_gen pg (
    .clk(clk), .par_wr(par_wr), .par_rd(par_rd), .par_num(par_num),
    .par_wdata(par_wdata), .par_rdata(par_rdata), .par_rvalid(par_rvalid),
    .sync_cmd(sync_cmd), .sync_type(sync_type));
  // ====
  // helpers
  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rdchk(input logic [7:0] num, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    pg.rd(num, d, ok);
    `CHK("read valid", 1'b1, ok)
    `CHK("read data", exp, d)
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // a missing tick runs both loops out and shows up as a wrong period
  task automatic tick_period(input int exp);
    int n;
    n = 0;
    while (bit_tick !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (bit_tick !== 1'b1 && n < 500);
    `CHK("bit tick period", exp, n)
  endtask
  // watch window is bounded; a missing pulse is reported, not waited for
  task automatic sync_watch(input logic t, input logic exp_tx);
    logic seen;
    seen = 1'b0;
    pg.sync(t);
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      if (tx_v === 1'b1) begin
        seen = 1'b1;
        `CHK("reference at transmit", ref_staged, act_ref)
        `CHK("transmit type", t, tx_t)
      end
    end
    `CHK("transmit seen", exp_tx, seen)
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end
  // ====
  // main sequence
  initial begin
    rst = 1'b1;
    mode = 4'h0;
    fbsel = 1'b0;
    res_d = 16'h0000;
    enc_d = 16'h0000;
    shaft = 16'h1234;
    rate_sel = 8'h00;
    gain = 16'h0100;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) rdchk(rows[i].num, 16'h0000);
    foreach (rows[i]) begin
      pg.wr(rows[i].num, rows[i].wdata);
      rdchk(rows[i].num, rows[i].exp);
    end
    settle(3);
    `CHK("low rate", 1'b1, low_rate)
    `CHK("short reply", 16'h00cd, reply)
    tick_period(int'(csp_pkg::CAN_SLOW_CYCLES));
    rate_sel = 8'h01;
    settle(3);
    `CHK("low rate off", 1'b0, low_rate)
    tick_period(int'(csp_pkg::CAN_FAST_CYCLES));
    pg.wr(8'h96, 16'h085c);
    settle(3);
    `CHK("shaft position", 32'h0000_1234, meas)
    `CHK("shaft reference", 32'h0000_1234, act_ref)
    `CHK("aux after shaft", 32'h0000_0000, aux)
    rdchk(8'h96, 16'h005c);
    sync_watch(1'b0, 1'b1);
    `CHK("captured position", 32'h0000_1234, tx_d)
    `CHK("active reference", ref_staged, act_ref)
    rdchk(8'h68, 16'h0064);
    rdchk(8'h96, 16'h005c);
    rdchk(8'h74, 16'h1234);
    pg.wr(8'h96, 16'h105c);
    settle(3);
    `CHK("follow reference", 32'h0000_1234, act_ref)
    `CHK("aux after follow", 32'h0000_0000, aux)
    mode = 4'hf;
    settle(30);
    `CHK("loop active", 1'b1, loop_on)
    `CHK("speed with ff", 16'h0064, speed)
    mode = 4'h0;
    settle(30);
    `CHK("speed loop off", 16'h0000, speed)
    fbsel = 1'b1;
    res_d = 16'h0003;
    settle(30);
    `CHK("encoder source", 32'h0000_1234, meas)
    fbsel = 1'b0;
    settle(30);
    `CHK("resolver source", 32'h0000_128e, meas)
    res_d = 16'h0000;
    pg.wr(8'h96, 16'h045c);
    settle(3);
    `CHK("zero position", 32'h0000_0000, meas)
    `CHK("zero reference", 32'h0000_0000, act_ref)
    pg.wr(8'h96, 16'h0040);
    settle(3);
    `CHK("full reply", 16'habcd, reply)
    sync_watch(1'b1, 1'b1);
    sync_watch(1'b0, 1'b0);
    pg.wr(8'h96, 16'h0004);
    sync_watch(1'b1, 1'b0);
    // reference 0x1111 against position 0, unity gain, plus ff 0x0064
    mode = 4'hf;
    settle(30);
    `CHK("speed with error", 16'h1175, speed)
    conclude();
  end
endmodule // can_sync_position_loop_tb
